// ===== leddr_pkg.sv
// Constants for the LED driver control register bank.
// Assumes an 8-bit register address and 8-bit data from the serial front end.
package leddr_pkg;

  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_STRING_ENABLE   = 8'h00;
  localparam logic [7:0] ADDR_DEVICE_CONFIG   = 8'h02;
  localparam logic [7:0] ADDR_FAULT_MASK      = 8'h08;
  localparam logic [7:0] ADDR_GLOBAL_CURRENT  = 8'h0e;
  localparam logic [7:0] ADDR_RESERVED        = 8'h10;
  localparam logic [7:0] ADDR_OPT_CONTROL     = 8'h11;
  localparam logic [7:0] ADDR_OPT_DAC_ONE     = 8'h14;
  localparam logic [7:0] ADDR_OPT_DAC_TWO     = 8'h15;
  localparam logic [7:0] ADDR_OPT_STATUS      = 8'h18;

  // ---------------------------------------------------------------
  // Power-up defaults held in the nonvolatile image
  // ---------------------------------------------------------------
  localparam logic [7:0] DEF_STRING_ENABLE    = 8'h0f;
  localparam logic [7:0] DEF_DEVICE_CONFIG    = 8'h4e;
  localparam logic [7:0] DEF_FAULT_MASK       = 8'h0f;
  localparam logic [7:0] DEF_GLOBAL_CURRENT   = 8'h7f;
  localparam logic [7:0] DEF_RESERVED         = 8'h04;
  localparam logic [7:0] DEF_OPT_CONTROL      = 8'h1a;

  // ---------------------------------------------------------------
  // Storage slots for the loaded registers
  // ---------------------------------------------------------------
  localparam int         NUM_LOADED           = 6;
  localparam logic [2:0] IDX_STRING_ENABLE    = 3'h0;
  localparam logic [2:0] IDX_DEVICE_CONFIG    = 3'h1;
  localparam logic [2:0] IDX_FAULT_MASK       = 3'h2;
  localparam logic [2:0] IDX_GLOBAL_CURRENT   = 3'h3;
  localparam logic [2:0] IDX_RESERVED         = 3'h4;
  localparam logic [2:0] IDX_OPT_CONTROL      = 3'h5;
  localparam logic [2:0] IDX_NONE             = 3'h7;
  localparam logic [2:0] IDX_LAST             = 3'h5;

  // Status field positions
  localparam int         POS_FB_IGNORE        = 5;
  localparam int         POS_OPT_STATE        = 3;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b01,
    ST_RUN  = 2'b10
  } leddr_state_e;

endpackage

// ===== leddr_regs.sv
// Control register bank with power-up load from the nonvolatile image.
// Assumes the serial front end presents one-cycle read/write strobes
// synchronous to clk_sys.
`timescale 1ns/1ps

module leddr_regs
  import leddr_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       en_pin,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic [7:0] opt_dac_one,
  input  wire logic [7:0] opt_dac_two,
  input  wire logic       feedback_ignore_flag,
  input  wire logic [1:0] optimizer_state_field,
  output logic      [7:0] reg_rdata_q,
  output logic            reg_rvalid_q,
  output logic            load_busy_q,
  output logic      [7:0] string_enable_bits_q,
  output logic      [7:0] device_configuration_q,
  output logic      [7:0] string_fault_monitor_mask_q,
  output logic      [7:0] global_string_current_q,
  output logic      [7:0] optimizer_control_q
);

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  // Map an address onto a storage slot, or none for unmapped/read-only
  function automatic logic [2:0] slot_of(input logic [7:0] a);
    unique case (a)
      ADDR_STRING_ENABLE:  slot_of = IDX_STRING_ENABLE;
      ADDR_DEVICE_CONFIG:  slot_of = IDX_DEVICE_CONFIG;
      ADDR_FAULT_MASK:     slot_of = IDX_FAULT_MASK;
      ADDR_GLOBAL_CURRENT: slot_of = IDX_GLOBAL_CURRENT;
      ADDR_RESERVED:       slot_of = IDX_RESERVED;
      ADDR_OPT_CONTROL:    slot_of = IDX_OPT_CONTROL;
      default:             slot_of = IDX_NONE;
    endcase
  endfunction

  // Default value stored in the nonvolatile image for each slot
  function automatic logic [7:0] image_of(input logic [2:0] s);
    unique case (s)
      IDX_STRING_ENABLE:  image_of = DEF_STRING_ENABLE;
      IDX_DEVICE_CONFIG:  image_of = DEF_DEVICE_CONFIG;
      IDX_FAULT_MASK:     image_of = DEF_FAULT_MASK;
      IDX_GLOBAL_CURRENT: image_of = DEF_GLOBAL_CURRENT;
      IDX_RESERVED:       image_of = DEF_RESERVED;
      IDX_OPT_CONTROL:    image_of = DEF_OPT_CONTROL;
      default:            image_of = 8'h00;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Load sequencer
  // ---------------------------------------------------------------
  leddr_state_e state_q, state_d;
  logic [2:0]   load_idx_q, load_idx_d;
  logic         en_q, en_d;
  logic         en_rise;
  logic         load_busy_d;

  assign en_rise = en_pin & ~en_q;

  // One slot per cycle; an enable edge restarts the walk from slot zero
  always_comb begin
    state_d    = state_q;
    load_idx_d = load_idx_q;
    en_d       = en_pin;
    if (en_rise) begin
      state_d    = ST_LOAD;
      load_idx_d = IDX_STRING_ENABLE;
    end else begin
      unique case (state_q)
        ST_LOAD: begin
          if (load_idx_q == IDX_LAST) begin
            state_d = ST_RUN;
          end else begin
            load_idx_d = load_idx_q + 3'h1;
          end
        end
        ST_RUN: begin
          load_idx_d = IDX_STRING_ENABLE;
        end
      endcase
    end
    // Busy flag follows the next state so the output is a plain flop
    load_busy_d = (state_d == ST_LOAD);
  end

  // Sequencer state, edge detector and busy flag
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_q     <= ST_LOAD;
      load_idx_q  <= IDX_STRING_ENABLE;
      en_q        <= 1'b0;
      load_busy_q <= 1'b1;
    end else begin
      state_q     <= state_d;
      load_idx_q  <= load_idx_d;
      en_q        <= en_d;
      load_busy_q <= load_busy_d;
    end
  end

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  logic [7:0] regs_q [NUM_LOADED];
  logic [7:0] regs_d [NUM_LOADED];
  logic [2:0] wr_slot;

  assign wr_slot = slot_of(reg_addr);

  // Loader owns the bank while busy; host writes before run state are dropped.
  // Read-only and unmapped addresses decode to no slot.
  always_comb begin
    for (int i = 0; i < NUM_LOADED; i++) begin
      regs_d[i] = regs_q[i];
    end
    if (state_q == ST_LOAD && !en_rise) begin
      regs_d[load_idx_q] = image_of(load_idx_q);
    end else if (state_q == ST_RUN && !en_rise && reg_wr &&
                 wr_slot != IDX_NONE && wr_slot != IDX_RESERVED) begin
      regs_d[wr_slot] = reg_wdata;
    end
  end

  // Contents are zero from reset until the loader has passed them
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_LOADED; i++) begin
        regs_q[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < NUM_LOADED; i++) begin
        regs_q[i] <= regs_d[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  logic [7:0] rdata_d;
  logic [7:0] status_word;

  always_comb begin
    status_word = 8'h00;
    status_word[POS_FB_IGNORE] = feedback_ignore_flag;
    status_word[POS_OPT_STATE +: 2] = optimizer_state_field;
  end

  // Unmapped addresses read zero; data appears one cycle after strobe
  always_comb begin
    rdata_d = 8'h00;
    unique case (reg_addr)
      ADDR_OPT_DAC_ONE: rdata_d = opt_dac_one;
      ADDR_OPT_DAC_TWO: rdata_d = opt_dac_two;
      ADDR_OPT_STATUS:  rdata_d = status_word;
      default: begin
        if (wr_slot != IDX_NONE) begin
          rdata_d = regs_q[wr_slot];
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      reg_rdata_q  <= 8'h00;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rdata_q  <= reg_rd ? rdata_d : 8'h00;
      reg_rvalid_q <= reg_rd;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign string_enable_bits_q        = regs_q[IDX_STRING_ENABLE];
  assign device_configuration_q      = regs_q[IDX_DEVICE_CONFIG];
  assign string_fault_monitor_mask_q = regs_q[IDX_FAULT_MASK];
  assign global_string_current_q     = regs_q[IDX_GLOBAL_CURRENT];
  assign optimizer_control_q         = regs_q[IDX_OPT_CONTROL];

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_load_walk;
    load_busy_q [*6] ##1 !load_busy_q;
  endsequence

  a_load_after_reset: assert property (
    @(posedge clk_sys) $rose(nrst) && !en_pin && !$past(en_pin)
      |-> s_load_walk)
    else $error("load walk after reset wrong length");

  a_string_en_default: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    $fell(load_busy_q) |-> string_enable_bits_q == DEF_STRING_ENABLE)
    else $error("string enable default wrong");

  a_config_default: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    $fell(load_busy_q) |-> device_configuration_q == DEF_DEVICE_CONFIG)
    else $error("configuration default wrong");

  a_mask_default: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    $fell(load_busy_q) |-> string_fault_monitor_mask_q == DEF_FAULT_MASK)
    else $error("fault mask default wrong");

  a_current_default: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    $fell(load_busy_q) |-> global_string_current_q == DEF_GLOBAL_CURRENT)
    else $error("global current default wrong");

  a_optctl_default: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    $fell(load_busy_q) |-> optimizer_control_q == DEF_OPT_CONTROL)
    else $error("optimizer control default wrong");

  a_enable_restore: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    en_pin && !en_q |=> load_busy_q && load_idx_q == IDX_STRING_ENABLE)
    else $error("enable edge did not restart load");

  a_ro_write_ignored: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    reg_wr && !load_busy_q && !en_rise && (reg_addr == ADDR_OPT_DAC_ONE ||
      reg_addr == ADDR_OPT_DAC_TWO || reg_addr == ADDR_OPT_STATUS)
    |=> $stable(string_enable_bits_q) && $stable(device_configuration_q)
      && $stable(string_fault_monitor_mask_q)
      && $stable(global_string_current_q) && $stable(optimizer_control_q))
    else $error("read-only write changed a register");

endmodule // leddr_regs

// ===== leddr_host.sv
// Host model on the register port, standing in for the serial front end.
// Assumes strobes are taken on clk_sys and answers come one cycle later.
`timescale 1ns/1ps

module leddr_host (
  input  wire logic       clk_sys,
  input  wire logic [7:0] reg_rdata_q,
  input  wire logic       reg_rvalid_q,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  // Idle bus at time zero; called by the bench so one process drives
  task automatic idle();
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h5a;
    reg_wdata = 8'ha5;
  endtask

  // One-cycle write; released lines show the inverse, not the old value
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  // One-cycle read; answer sampled after the edge that follows
  task automatic read(input logic [7:0] a, output logic [7:0] d,
                      output logic v);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata_q;
    v = reg_rvalid_q;
  endtask
endmodule // leddr_host

// ===== tb_leddr_regs.sv
// Self-checking bench for the control register bank.
// Assumes the host model drives the register port; bench drives the rest.
`timescale 1ns/1ps

module tb_leddr_regs
  import leddr_pkg::*;
;
  logic clk_sys, nrst, en_pin, reg_wr, reg_rd, rvalid, busy, fbi;
  logic [7:0] addr, wdata, rdata, dac1, dac2, se, dc, fm, gc, oc, d;
  logic [1:0] ost;
  logic [7:0] ad [6] = '{8'h00, 8'h02, 8'h08, 8'h0e, 8'h11, 8'h10};
  logic [7:0] df [6] = '{8'h0f, 8'h4e, 8'h0f, 8'h7f, 8'h1a, 8'h04};
  logic [7:0] mir [6];
  logic [7:0] ro [3] = '{8'h14, 8'h15, 8'h18};
  integer seed = 32'h6da21cd3;
  int n_mismatch = 0;
  int n_checks = 0;
  int i;

  always #5 clk_sys = ~clk_sys;

  leddr_regs DUT (.clk_sys(clk_sys), .nrst(nrst), .en_pin(en_pin),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(addr), .reg_wdata(wdata),
    .opt_dac_one(dac1), .opt_dac_two(dac2), .feedback_ignore_flag(fbi),
    .optimizer_state_field(ost), .reg_rdata_q(rdata),
    .reg_rvalid_q(rvalid), .load_busy_q(busy), .string_enable_bits_q(se),
    .device_configuration_q(dc), .string_fault_monitor_mask_q(fm),
    .global_string_current_q(gc), .optimizer_control_q(oc));

  leddr_host u_host (.clk_sys(clk_sys), .reg_rdata_q(rdata),
    .reg_rvalid_q(rvalid), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(addr), .reg_wdata(wdata));

  // Compare and count
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask

  // Read one register and compare data and valid
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] g;
    logic v;
    u_host.read(a, g, v);
    chk("rvalid", 8'h01, {7'h0, v});
    chk("rdata", e, g);
  endtask

  // Wait for the default load to finish, bounded
  task automatic wait_load();
    int k;
    k = 0;
    while (k < 20 && busy !== 1'b0) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    chk("load_busy_q", 8'h00, {7'h0, busy});
  endtask

  // Register outputs against the mirror of what the bench wrote
  task automatic chk_ports();
    chk("string_enable_bits_q", mir[0], se);
    chk("device_configuration_q", mir[1], dc);
    chk("string_fault_monitor_mask_q", mir[2], fm);
    chk("global_string_current_q", mir[3], gc);
    chk("optimizer_control_q", mir[4], oc);
  endtask

  // All loaded registers at their defaults by bus, and all but the reserved one by port
  task automatic chk_defaults();
    for (int j = 0; j < 6; j++) begin
      rd_chk(ad[j], df[j]);
      mir[j] = df[j];
    end
    chk_ports();
  endtask

  // Verdict, reached from the main sequence or the watchdog
  task automatic results();
    if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Watchdog: the run needs well under a thousand cycles
  initial begin
    #100000;
    n_mismatch++;
    results();
  end

  // Main sequence
  initial begin
    clk_sys = 1'b0;
    nrst = 1'b0;
    en_pin = 1'b0;
    {dac1, dac2, fbi, ost} = '0;
    u_host.idle();
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    wait_load();
    chk_defaults();
    // Random writes, read-only pokes and live status reads
    for (int n = 0; n < 30; n++) begin
      i = $unsigned($random(seed)) % 6;
      d = 8'($random(seed));
      u_host.write(ad[i], d);
      if (i < 5) mir[i] = d;
      rd_chk(ad[i], mir[i]);
      @(posedge clk_sys);
      {dac1, dac2} <= 16'($random(seed));
      {fbi, ost} <= 3'($random(seed));
      u_host.write(ro[i % 3], d);
      rd_chk(8'h14, dac1);
      rd_chk(8'h15, dac2);
      rd_chk(8'h18, {2'b00, fbi, ost, 3'b000});
      u_host.write(8'h18, d);
      rd_chk(8'h18, {2'b00, fbi, ost, 3'b000});
      chk_ports();
    end
    rd_chk(8'h01, 8'h00);
    // Move every writable register off its default first
    for (int j = 0; j < 5; j++) begin
      u_host.write(ad[j], ~df[j]);
      mir[j] = ~df[j];
    end
    #1;
    chk_ports();
    // Enable pin rising restores every default; a write taken after
    // slot zero has reloaded must be dropped, not land on top of it
    @(posedge clk_sys);
    en_pin <= 1'b1;
    repeat (2) @(posedge clk_sys);
    u_host.write(8'h00, 8'h00);
    wait_load();
    en_pin <= 1'b0;
    chk_defaults();
    results();
  end
endmodule // tb_leddr_regs
